// ===== rmrc_pkg.sv
// constants for the reset manager and regulator control block
// assumes one 100 MHz clock; all counts are in clk_sys cycles except SEC_CNT, which counts secondary-clock ticks
package rmrc_pkg;
   localparam int CLK_MHZ      = 100;
   // reset release: source-clock cycles, then secondary-clock ticks
   localparam int MAIN_CNT     = 2048;
   localparam int SEC_CNT      = 8;
   // secondary clock is a divided enable of the source clock
   localparam int SEC_DIV      = 4;
   // least low time of the reset pin, done by the board, not checked
   localparam int PIN_MIN_NS   = 1000;
   localparam int PIN_MIN_CYC  = (PIN_MIN_NS * CLK_MHZ + 999) / 1000;
   // clock_flag_reg bit positions
   localparam int FLG_SOFT     = 0;
   localparam int FLG_WDG      = 1;
   localparam int FLG_WAKE     = 2;
   localparam int FLG_RTC      = 3;
   localparam int FLG_W        = 4;
   localparam logic [FLG_W-1:0] FLAGS_RST = 4'h0;
   // reset vector address loaded into the program counter
   localparam logic [31:0] RESET_VECTOR = 32'h0000_0000;
   // clock frequency limit when the main regulator is off
   localparam int LP_MAX_KHZ   = 1000;
   typedef enum logic [1:0] {
      RMRC_RUN,
      RMRC_HOLD,
      RMRC_MAIN,
      RMRC_SEC
   } rmrc_state_t;
endpackage : rmrc_pkg

// ===== rmrc_top.sv
// reset manager and regulator control: gathers reset sources,
// records the cause, times the release, drives regulator enables
// assumes pins are asynchronous; control bits come from same-clock logic
//
// What this block does
// RULE1 - pin low starts reset without clock
// RULE2 - soft reset only when both enables set
// RULE3 - undervoltage detector forces reset
// RULE4 - watchdog expiry forces reset
// RULE5 - wake pin in standby forces reset
// RULE6 - rtc alarm in standby forces reset
// RULE7 - flag the cause of last reset
// RULE8 - pin or undervoltage reset clears flags
// RULE9 - pin reset overrides every other condition
// RULE10 - registers and pins take reset values
// RULE11 - release after 2048 plus 8 cycles
// RULE12 - release may take one extra cycle
// RULE13 - load program counter from reset vector
// RULE14 - board holds pin low at least 1us
// RULE15 - main regulator off in standby
// RULE16 - main regulator off in wait if enabled
// RULE17 - pll disabled while main regulator off
// RULE18 - stable bit only when regulator settled
// RULE19 - software may bypass low power regulator
// RULE20 - main undervoltage detector never disabled
// RULE21 - reset released synchronously to source clock
`timescale 1ns/1ps
module rmrc_top
   import rmrc_pkg::*;
#(
   parameter int MAIN_CYCLES = MAIN_CNT,
   parameter int SEC_CYCLES  = SEC_CNT,
   parameter int SEC_DIVIDE  = SEC_DIV
) (
   input  wire logic              clk_sys,
   input  wire logic              rst,
   input  wire logic              ext_reset_pin_n,
   input  wire logic              undervoltage_detector,
   input  wire logic              wake_pin,
   input  wire logic              rtc_alarm,
   input  wire logic              soft_reset_trigger,
   input  wire logic              soft_reset_allow,
   input  wire logic              halt_trigger_enable,
   input  wire logic              watchdog_expire,
   input  wire logic              standby_mode,
   input  wire logic              wfi_mode,
   input  wire logic              low_power_regulator_on_wait,
   input  wire logic              pll_enable_req,
   input  wire logic              regulator_settled,
   input  wire logic              backup_supply_present,
   input  wire logic              lp_regulator_off_req,
   input  wire logic [FLG_W-1:0]  flag_clear,
   output logic                   sys_reset,
   output logic                   io_reset_config,
   output logic                   pc_load,
   output logic [31:0]            pc_value,
   output logic [FLG_W-1:0]       clock_flag_reg,
   output logic                   main_regulator_on,
   output logic                   lp_regulator_on,
   output logic                   lp_detector_enable,
   output logic                   main_detector_enable,
   output logic                   pll_enable,
   output logic                   main_regulator_stable
);
   ////////////////////////////////////////////////////////////////
   // pin reset path
   // RULE1 async start
   // pin low resets the sequencer at once, no clock needed
   logic pin_rst;
   assign pin_rst = rst | ~ext_reset_pin_n;

   // synchronisers; first stage feeds only the second
   logic pin_s1_q, pin_s2_q;
   logic lvd_s1_q, lvd_s2_q;
   logic wak_s1_q, wak_s2_q;
   logic rtc_s1_q, rtc_s2_q;
   logic set_s1_q, set_s2_q;

   // RULE12 sync delay
   // the pin is seen high only after two edges, so release
   // may slip one source-clock period with pin phase
   always_ff @(posedge clk_sys or posedge pin_rst) begin
      if (pin_rst) begin
         pin_s1_q <= 1'b0;
         pin_s2_q <= 1'b0;
      end else begin
         pin_s1_q <= 1'b1;
         pin_s2_q <= pin_s1_q;
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         lvd_s1_q <= 1'b0;
         lvd_s2_q <= 1'b0;
         wak_s1_q <= 1'b0;
         wak_s2_q <= 1'b0;
         rtc_s1_q <= 1'b0;
         rtc_s2_q <= 1'b0;
         set_s1_q <= 1'b0;
         set_s2_q <= 1'b0;
      end else begin
         lvd_s1_q <= undervoltage_detector;
         lvd_s2_q <= lvd_s1_q;
         wak_s1_q <= wake_pin;
         wak_s2_q <= wak_s1_q;
         rtc_s1_q <= rtc_alarm;
         rtc_s2_q <= rtc_s1_q;
         set_s1_q <= regulator_settled;
         set_s2_q <= set_s1_q;
      end
   end

   ////////////////////////////////////////////////////////////////
   // reset sources
   logic soft_req, wdg_req, wake_req, rtc_req, any_req, src_lvl;
   // RULE2 soft gate
   assign soft_req = soft_reset_trigger & soft_reset_allow
                     & halt_trigger_enable;
   // RULE4 watchdog source
   assign wdg_req  = watchdog_expire;
   // RULE5 wake in standby
   assign wake_req = standby_mode & wak_s2_q;
   // RULE6 alarm in standby
   assign rtc_req  = standby_mode & rtc_s2_q;
   // RULE3 undervoltage source
   // RULE20 detector always on
   // the main detector enable is tied high; its output always counts
   assign any_req  = lvd_s2_q | soft_req | wdg_req | wake_req | rtc_req;
   // level sources keep the sequencer held until they go away
   // RULE9 pin overrides
   assign src_lvl  = ~pin_s2_q | lvd_s2_q;

   ////////////////////////////////////////////////////////////////
   // release sequencer
   localparam int CW = $clog2(MAIN_CYCLES + 1);
   localparam int DW = $clog2(SEC_DIVIDE + 1);
   localparam logic [CW-1:0] MAIN_LAST = CW'(MAIN_CYCLES - 1);
   localparam logic [CW-1:0] SEC_LAST  = CW'(SEC_CYCLES - 1);
   localparam logic [DW-1:0] DIV_LAST  = DW'(SEC_DIVIDE - 1);

   rmrc_state_t state_q, state_d;
   logic [CW-1:0] cnt_q, cnt_d;
   logic [DW-1:0] div_q;
   logic          sec_en;
   logic          sys_reset_q;
   logic          pc_load_q;

   // secondary clock as a one-cycle enable
   assign sec_en = (div_q == DIV_LAST);

   always_ff @(posedge clk_sys or posedge pin_rst) begin
      if (pin_rst) begin
         div_q <= '0;
      end else if (sec_en) begin
         div_q <= '0;
      end else begin
         div_q <= div_q + DW'(1);
      end
   end

   always_comb begin
      state_d = state_q;
      cnt_d   = cnt_q;
      case (state_q)
         RMRC_RUN: begin
            if (any_req) begin
               state_d = RMRC_HOLD;
            end
         end
         RMRC_HOLD: begin
            cnt_d = '0;
            if (!src_lvl) begin
               state_d = RMRC_MAIN;
            end
         end
         // RULE11 main count
         RMRC_MAIN: begin
            cnt_d = cnt_q + CW'(1);
            if (src_lvl) begin
               state_d = RMRC_HOLD;
            end else if (cnt_q == MAIN_LAST) begin
               state_d = RMRC_SEC;
               cnt_d   = '0;
            end
         end
         // RULE11 secondary count
         RMRC_SEC: begin
            if (src_lvl) begin
               state_d = RMRC_HOLD;
            end else if (sec_en) begin
               cnt_d = cnt_q + CW'(1);
               if (cnt_q == SEC_LAST) begin
                  state_d = RMRC_RUN;
               end
            end
         end
         default: begin
            state_d = RMRC_HOLD;
         end
      endcase
   end

   // RULE21 sync release
   // asserted asynchronously by the pin, on a clock edge by other sources, released only on a clock edge
   always_ff @(posedge clk_sys or posedge pin_rst) begin
      if (pin_rst) begin
         state_q     <= RMRC_HOLD;
         cnt_q       <= '0;
         sys_reset_q <= 1'b1;
         pc_load_q   <= 1'b0;
      end else begin
         state_q     <= state_d;
         cnt_q       <= cnt_d;
         sys_reset_q <= (state_d != RMRC_RUN);
         pc_load_q   <= (state_q == RMRC_SEC) && (state_d == RMRC_RUN);
      end
   end

   // RULE10 reset config
   // io and register resets follow the held system reset
   assign sys_reset       = sys_reset_q;
   assign io_reset_config = sys_reset_q;
   // RULE13 reset vector
   assign pc_load         = pc_load_q;
   assign pc_value        = RESET_VECTOR;

   ////////////////////////////////////////////////////////////////
   // cause flags
   logic [FLG_W-1:0] flags_q, flags_d, cause;
   logic             take;
   assign take = (state_q == RMRC_RUN) && any_req && !lvd_s2_q;
   always_comb begin
      cause = '0;
      cause[FLG_SOFT] = soft_req;
      cause[FLG_WDG]  = wdg_req;
      cause[FLG_WAKE] = wake_req;
      cause[FLG_RTC]  = rtc_req;
   end
   // RULE7 cause flag
   // RULE8 clear on lvd
   // a new cause wins over a software clear in the same cycle
   assign flags_d = lvd_s2_q ? FLAGS_RST
                  : take     ? cause
                  : (flags_q & ~flag_clear);

   // pin reset clears every flag asynchronously
   always_ff @(posedge clk_sys or posedge pin_rst) begin
      if (pin_rst) begin
         flags_q <= FLAGS_RST;
      end else begin
         flags_q <= flags_d;
      end
   end
   assign clock_flag_reg = flags_q;

   ////////////////////////////////////////////////////////////////
   // regulator control
   logic main_on, stable_q;
   // RULE15 standby off
   // RULE16 wait off
   assign main_on = ~standby_mode & ~(wfi_mode & low_power_regulator_on_wait);
   assign main_regulator_on = main_on;
   // RULE17 pll off
   // low power supply cannot feed pll speed; limit is 1 MHz
   assign pll_enable = main_on & pll_enable_req;
   // RULE19 lp bypass
   assign lp_regulator_on = ~(lp_regulator_off_req & backup_supply_present);
   // lp detector may go off only with its regulator
   assign lp_detector_enable   = lp_regulator_on;
   // RULE20 detector enable
   assign main_detector_enable = 1'b1;

   // RULE18 stable flag
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         stable_q <= 1'b0;
      end else begin
         stable_q <= set_s2_q & main_on;
      end
   end
   assign main_regulator_stable = stable_q;

   ////////////////////////////////////////////////////////////////
   // checks
   pin_override_a: assert property (@(posedge clk_sys) disable iff (rst) // RULE9
      !pin_s2_q |-> sys_reset_q)
      else $error("pin low but system reset not held");
   soft_gate_a: assert property (@(posedge clk_sys) disable iff (rst) // RULE2
      (state_q == RMRC_RUN && soft_reset_trigger && !(soft_reset_allow && halt_trigger_enable)
       && !lvd_s2_q && !wdg_req && !wake_req && !rtc_req && pin_s2_q)
      |=> !sys_reset_q)
      else $error("soft reset taken without allow bit");
   lvd_reset_a: assert property (@(posedge clk_sys) disable iff (rst) // RULE3
      lvd_s2_q |=> sys_reset_q && flags_q == FLAGS_RST)
      else $error("undervoltage did not reset or clear flags");
   wdg_flag_a: assert property (@(posedge clk_sys) disable iff (rst) // RULE4
      (state_q == RMRC_RUN && wdg_req && !lvd_s2_q && pin_s2_q)
      |=> sys_reset_q && flags_q[FLG_WDG])
      else $error("watchdog reset not taken or not flagged");
   wake_rst_a: assert property (@(posedge clk_sys) disable iff (rst) // RULE5
      (state_q == RMRC_RUN && wake_req && !lvd_s2_q && pin_s2_q)
      |=> sys_reset_q && flags_q[FLG_WAKE])
      else $error("standby wake did not reset");
   rtc_rst_a: assert property (@(posedge clk_sys) disable iff (rst) // RULE6
      (state_q == RMRC_RUN && standby_mode && rtc_s2_q && !lvd_s2_q && pin_s2_q)
      |=> sys_reset_q && flags_q[FLG_RTC])
      else $error("standby alarm did not reset or not flagged");
   main_count_a: assert property (@(posedge clk_sys) disable iff (rst) // RULE11
      (state_q == RMRC_MAIN && state_d == RMRC_SEC) |-> cnt_q == MAIN_LAST)
      else $error("main release count wrong");
   pc_load_a: assert property (@(posedge clk_sys) disable iff (rst) // RULE13
      pc_load |-> $past(state_q) == RMRC_SEC && !sys_reset_q
      && pc_value == RESET_VECTOR)
      else $error("program counter load out of place");
   standby_off_a: assert property (@(posedge clk_sys) disable iff (rst) // RULE15
      standby_mode |-> !main_regulator_on && !pll_enable)
      else $error("main regulator on in standby");
   pll_off_a: assert property (@(posedge clk_sys) disable iff (rst) // RULE17
      !main_regulator_on |-> !pll_enable)
      else $error("pll on with main regulator off");
   stable_a: assert property (@(posedge clk_sys) disable iff (rst) // RULE18
      !main_regulator_on |=> !main_regulator_stable)
      else $error("stable bit with regulator off");
   soft_flag_a: assert property (@(posedge clk_sys) disable iff (rst) // RULE7
      (state_q == RMRC_RUN && soft_req && !lvd_s2_q && pin_s2_q)
      |=> sys_reset_q && flags_q[FLG_SOFT])
      else $error("soft reset not taken or not flagged");
   reset_hold_a: assert property (@(posedge clk_sys) disable iff (rst) // RULE10
      state_q != RMRC_RUN |-> sys_reset && io_reset_config)
      else $error("system or io reset dropped before release");
   pin_sync_a: assert property (@(posedge clk_sys) disable iff (rst) // RULE12
      $rose(pin_s2_q) |-> sys_reset_q && state_q == RMRC_HOLD)
      else $error("count started before pin seen high");
   wait_off_a: assert property (@(posedge clk_sys) disable iff (rst) // RULE16
      wfi_mode && low_power_regulator_on_wait |-> !main_regulator_on && !pll_enable)
      else $error("main regulator on in low power wait");
   lp_bypass_a: assert property (@(posedge clk_sys) disable iff (rst) // RULE19
      !backup_supply_present |-> lp_regulator_on && lp_detector_enable)
      else $error("low power regulator off without backup supply");
   sync_release_a: assert property (@(posedge clk_sys) disable iff (rst) // RULE21
      $fell(sys_reset_q) |-> $past(state_q) == RMRC_SEC && $past(sec_en)
      && $past(cnt_q) == SEC_LAST)
      else $error("system reset released off a secondary tick");
endmodule : rmrc_top

// ===== rmrc_partner.sv
// board side model: reset circuit, supply monitor and wake sources
// assumes bench commands change just after clk_sys rises
`timescale 1ns/1ps
module rmrc_partner
   import rmrc_pkg::*;
(
   input  wire logic clk_sys,
   input  wire logic pin_go,
   input  wire logic lvd_go,
   input  wire logic wake_go,
   input  wire logic rtc_go,
   input  wire logic settle_go,
   output logic      ext_reset_pin_n,
   output logic      undervoltage_detector,
   output logic      wake_pin,
   output logic      rtc_alarm,
   output logic      regulator_settled
);
   int low_cnt = 0;
   ////////////////////////////////////////////////////////////
   // pin held low
   // a shorter pulse may be filtered, so never send one
   always @(posedge clk_sys) begin
      if (pin_go) low_cnt <= PIN_MIN_CYC;
      else if (low_cnt > 0) low_cnt <= low_cnt - 1;
   end
   assign ext_reset_pin_n       = !(pin_go || low_cnt > 0);
   assign undervoltage_detector = lvd_go;
   assign wake_pin              = wake_go;
   assign rtc_alarm             = rtc_go;
   assign regulator_settled     = settle_go;
endmodule : rmrc_partner

// ===== reset_manager_and_regulator_ctrl_bench.sv
// self-checking bench for the reset manager and regulator control
// assumes short release counts 16/2/2 handed to the design
`timescale 1ns/1ps
module reset_manager_and_regulator_ctrl_bench;
   import rmrc_pkg::*;
   localparam int MC = 16, SC = 2, SD = 2;
   logic clk_sys = 0, rst = 1, soft_reset_trigger = 0, soft_reset_allow = 0, halt_trigger_enable = 0;
   logic watchdog_expire = 0, standby_mode = 0, wfi_mode = 0, low_power_regulator_on_wait = 0;
   logic pll_enable_req = 0, backup_supply_present = 0, lp_regulator_off_req = 0;
   logic pin_go = 0, lvd_go = 0, wake_go = 0, rtc_go = 0, settle_go = 0;
   logic [FLG_W-1:0] flag_clear = 4'h0;
   logic ext_reset_pin_n, undervoltage_detector, wake_pin, rtc_alarm, regulator_settled;
   logic sys_reset, io_reset_config, pc_load, main_regulator_on, lp_regulator_on;
   logic lp_detector_enable, main_detector_enable, pll_enable, main_regulator_stable;
   logic [31:0] pc_value;
   logic [FLG_W-1:0] clock_flag_reg;
   int err_count = 0, check_count = 0, cyc = 0, n;
   rmrc_partner PART (.clk_sys, .pin_go, .lvd_go, .wake_go, .rtc_go, .settle_go, .ext_reset_pin_n,
      .undervoltage_detector, .wake_pin, .rtc_alarm, .regulator_settled);
   rmrc_top #(.MAIN_CYCLES(MC), .SEC_CYCLES(SC), .SEC_DIVIDE(SD)) DUT (.clk_sys, .rst, .ext_reset_pin_n,
      .undervoltage_detector, .wake_pin, .rtc_alarm, .soft_reset_trigger, .soft_reset_allow,
      .halt_trigger_enable, .watchdog_expire, .standby_mode, .wfi_mode, .low_power_regulator_on_wait,
      .pll_enable_req, .regulator_settled, .backup_supply_present, .lp_regulator_off_req, .flag_clear,
      .sys_reset, .io_reset_config, .pc_load, .pc_value, .clock_flag_reg, .main_regulator_on,
      .lp_regulator_on, .lp_detector_enable, .main_detector_enable, .pll_enable, .main_regulator_stable);
   initial forever #5 clk_sys = ~clk_sys;
   ////////////////////////////////////////////////////////////
   // a hang costs at most 6000 cycles
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (cyc == 6000) begin
         err_count++;
         $display("CHECK FAILED t=%0t timeout", $time);
         summarize();
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
      check_count++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED t=%0t %s got %h exp %h", $time, msg, got, exp);
      end
   endtask : chk
   task automatic step(input int k);
      repeat (k) @(posedge clk_sys);
      #1;
   endtask : step
   task automatic rel(output int k);
      k = 0;
      while (sys_reset !== 1'b0 && k < 400) begin
         step(1);
         k++;
      end
      chk(pc_load, 1'b1, "pc load at release");
      chk(pc_value, RESET_VECTOR, "pc value");
      chk(io_reset_config, 1'b0, "io config released");
      step(1);
      chk(pc_load, 1'b0, "pc load one cycle");
   endtask : rel
   task automatic cause(input logic [FLG_W-1:0] f, input logic r);
      step(4);
      chk(sys_reset, r, "reset taken");
      chk(io_reset_config, r, "io config in reset");
      chk(clock_flag_reg, f, "cause flags");
      if (r) rel(n);
   endtask : cause
   task automatic t_soft;
      for (int i = 0; i < 4; i++) begin
         soft_reset_allow = i[0];
         halt_trigger_enable = i[1];
         soft_reset_trigger = 1;
         step(1);
         soft_reset_trigger = 0;
         cause(i == 3 ? 4'h1 : 4'h0, i == 3);
      end
      watchdog_expire = 1;
      step(1);
      watchdog_expire = 0;
      cause(4'h2, 1);
      flag_clear = 4'h2;
      step(1);
      flag_clear = 4'h0;
      chk(clock_flag_reg, 4'h0, "flag clear");
      $display("soft and watchdog test done");
   endtask : t_soft
   task automatic t_wake;
      for (int i = 0; i < 4; i++) begin
         standby_mode = i[1];
         wake_go = !i[0];
         rtc_go = i[0];
         step(2);
         wake_go = 0;
         rtc_go = 0;
         cause(i < 2 ? 4'h0 : (i[0] ? 4'h8 : 4'h4), i >= 2);
      end
      standby_mode = 0;
      $display("wake test done");
   endtask : t_wake
   task automatic t_pin;
      pin_go = 1;
      watchdog_expire = 1;
      #1;
      chk(sys_reset, 1'b1, "pin reset without edge");
      chk(clock_flag_reg, 4'h0, "pin clears flags");
      step(1);
      pin_go = 0;
      watchdog_expire = 0;
      rel(n);
      chk(clock_flag_reg, 4'h0, "pin overrides watchdog");
      watchdog_expire = 1;
      step(1);
      watchdog_expire = 0;
      cause(4'h2, 1);
      lvd_go = 1;
      step(3);
      lvd_go = 0;
      cause(4'h0, 1);
      $display("pin and undervoltage test done");
   endtask : t_pin
   task automatic t_reg;
      for (int i = 0; i < 16; i++) begin
         {standby_mode, wfi_mode, low_power_regulator_on_wait, pll_enable_req} = i[3:0];
         {backup_supply_present, lp_regulator_off_req} = i[1:0];
         step(1);
         chk(main_regulator_on, !i[3] && !(i[2] && i[1]), "main regulator");
         chk(pll_enable, !i[3] && !(i[2] && i[1]) && i[0], "pll enable");
         chk(lp_regulator_on, !(i[1] && i[0]), "lp regulator");
         chk(lp_detector_enable, !(i[1] && i[0]), "lp detector");
         chk(main_detector_enable, 1'b1, "main detector");
      end
      {standby_mode, wfi_mode, low_power_regulator_on_wait, pll_enable_req} = 4'h0;
      {backup_supply_present, lp_regulator_off_req} = 2'h0;
      step(1);
      chk(main_regulator_stable, 1'b0, "stable before settle");
      settle_go = 1;
      step(4);
      chk(main_regulator_stable, 1'b1, "stable after settle");
      standby_mode = 1;
      step(4);
      chk(main_regulator_stable, 1'b0, "stable with regulator off");
      standby_mode = 0;
      $display("regulator test done");
   endtask : t_reg
   task automatic summarize;
      $display("checks %0d mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : summarize
   initial begin
      repeat (20) @(posedge clk_sys);
      #1 rst = 0;
      rel(n);
      chk(n >= MC + (SC - 1) * SD + 1 && n <= MC + SC * SD + 5, 1'b1, "release count");
      chk(clock_flag_reg, 4'h0, "flags after boot");
      $display("boot test done");
      t_soft();
      t_wake();
      t_pin();
      t_reg();
      summarize();
   end
endmodule : reset_manager_and_regulator_ctrl_bench
